// ==== pkg/vqb_pkg.sv ====
// Purpose: shared constants and types for the channel arbiter and broadcast layer
// Assumes: one clock domain at 20 MHz
// Notes: register offsets are byte addresses of aligned 32-bit words
package vqb_pkg;
	// sizes
	localparam int NVC = 4;
	localparam int VCW = 2;
	localparam int NSLOT = 8;
	localparam int SLW = 3;
	localparam int PRW = 3;
	localparam int BWW = 10;
	localparam int PRECW = 1 + PRW + BWW;
	localparam int FCW = 6;
	localparam int WORDW = 36;
	localparam int NBC = 256;
	localparam int BCW = 8;
	localparam int SEQW = 8;
	localparam int TYPW = 8;
	localparam int PAYW = 64;
	localparam int AW = 8;
	localparam int DW = 32;
	localparam logic [FCW-1:0] FRAME_LAST = 6'h3f; // 64 words, 256 chars
	// register offsets
	localparam logic [AW-1:0] REG_CTRL = 8'h00;
	localparam logic [AW-1:0] REG_STATUS = 8'h04;
	localparam logic [AW-1:0] REG_TYPE_MASK = 8'h08;
	localparam logic [AW-1:0] REG_SUB = 8'h0c;
	localparam logic [AW-1:0] REG_LTIME = 8'h10;
	localparam logic [AW-1:0] REG_VC_CFG = 8'h20;
	// field positions
	localparam int CTRL_SLOT_SRC = 0;
	localparam int CTRL_ARB_EN = 1;
	localparam int CFG_PRIO = 0;
	localparam int CFG_CLASS = 4;
	localparam int CFG_RSV = 8;
	localparam int CFG_SLOT = 16;
	localparam int SUB_ON = 8;
	localparam int LTIME_SLOT = 10;
	localparam int ST_VC = 4;
	localparam int ST_BUSY = 7;
	// reset values and share cost per word
	localparam logic [DW-1:0] CTRL_RST = 32'h0000_0002;
	localparam logic [DW-1:0] CFG_RST = 32'h00ff_0010;
	localparam logic [DW-1:0] TYPE_MASK_RST = 32'hffff_ffff;
	localparam logic [BWW-1:0] BW_RST = 10'h200;
	localparam logic [BWW+1:0] BW_COST = 12'h100;
	// broadcast channel groups and types
	localparam logic [BCW-1:0] BC_TIME_HI = 8'h03;
	localparam logic [BCW-1:0] BC_SYNC_LO = 8'h04;
	localparam logic [BCW-1:0] BC_SYNC_HI = 8'h07;
	localparam logic [BCW-1:0] BC_NODE_HI = 8'hfd;
	localparam logic [TYPW-1:0] TYPE_TIME = 8'h01; // arbitrary code
	typedef enum logic [1:0] {CL_BEST = 2'b00, CL_PRIO = 2'b01, CL_BW = 2'b10, CL_SCHED = 2'b11} vqb_class_t;
	typedef enum logic [1:0] {ST_ARB = 2'b00, ST_SEND = 2'b01, ST_GAP = 2'b11} vqb_state_t;
	// channels 254 and 255 carry nothing
	function automatic logic vqb_is_rsv(input logic [BCW-1:0] chan);
		return chan > BC_NODE_HI;
	endfunction
endpackage

// ==== verilog/vqb_arb.sv ====
// Purpose: pick the eligible channel with the highest precedence
// Assumes: NVC is a power of two so the index wraps by itself
// Notes: purely combinational, the caller registers the grant
`timescale 1ns/1ps
`default_nettype none
module vqb_arb (
	// candidates
	input wire logic [vqb_pkg::NVC-1:0] elig,
	input wire logic [vqb_pkg::NVC*vqb_pkg::PRECW-1:0] prec,
	input wire logic [vqb_pkg::VCW-1:0] rr,
	// result
	output logic found,
	output logic [vqb_pkg::VCW-1:0] win
);
	// scan from the rotating start, only strictly higher displaces
	always_comb begin
		logic [vqb_pkg::VCW-1:0] idx;
		logic [vqb_pkg::PRECW-1:0] best;
		logic [vqb_pkg::PRECW-1:0] p;
		idx = rr;
		best = '0;
		p = '0;
		found = 1'b0;
		win = rr;
		for (int k = 0; k < vqb_pkg::NVC; k++) begin
			idx = rr + k[vqb_pkg::VCW-1:0];
			p = prec[idx*vqb_pkg::PRECW +: vqb_pkg::PRECW];
			if (elig[idx] && (!found || p > best)) begin
				found = 1'b1;
				win = idx;
				best = p;
			end
		end
	end
endmodule
`default_nettype wire

// ==== verilog/vqb_brx.sv ====
// Purpose: broadcast receive check, per-channel sequence state, subscriptions
// Assumes: framing layer presents only error-free broadcasts
// Notes: outputs are registered one cycle after the input strobe
`timescale 1ns/1ps
`default_nettype none
module vqb_brx (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// from framing layer
	input wire logic in_valid,
	input wire logic [vqb_pkg::BCW-1:0] in_chan,
	input wire logic [vqb_pkg::SEQW-1:0] in_seq,
	input wire logic [vqb_pkg::TYPW-1:0] in_type,
	input wire logic [vqb_pkg::PAYW-1:0] in_data,
	// subscription control
	input wire logic sub_wr,
	input wire logic [vqb_pkg::BCW-1:0] sub_chan,
	input wire logic sub_on,
	input wire logic [31:0] type_mask,
	// accepted message
	output logic acc,
	output logic dlv,
	output logic [vqb_pkg::BCW-1:0] d_chan,
	output logic [vqb_pkg::SEQW-1:0] d_seq,
	output logic [vqb_pkg::TYPW-1:0] d_type,
	output logic [vqb_pkg::PAYW-1:0] d_data
);
	logic [vqb_pkg::SEQW-1:0] last_seq [vqb_pkg::NBC];
	logic [vqb_pkg::NBC-1:0] known;
	logic [vqb_pkg::NBC-1:0] subd;
	logic ok;
	logic want;

	// first message after reset is taken, then modular plus one
	assign ok = in_valid && !vqb_pkg::vqb_is_rsv(in_chan)
		&& (!known[in_chan] || in_seq == last_seq[in_chan] + 8'h01);
	assign want = subd[in_chan] && type_mask[in_type[4:0]];

	// reference sequence per channel
	always_ff @(posedge clk) begin
		if (ok) begin
			last_seq[in_chan] <= in_seq;
		end
	end

	// channel reference valid flags and subscriptions
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			known <= '0;
			subd <= '0;
		end else begin
			if (ok) begin
				known[in_chan] <= 1'b1;
			end
			if (sub_wr) begin
				subd[sub_chan] <= sub_on;
			end
		end
	end

	// registered hand-over to user logic
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			acc <= 1'b0;
			dlv <= 1'b0;
			d_chan <= '0;
			d_seq <= '0;
			d_type <= '0;
			d_data <= '0;
		end else begin
			acc <= ok;
			dlv <= ok && want;
			if (ok) begin
				d_chan <= in_chan;
				d_seq <= in_seq;
				d_type <= in_type;
				d_data <= in_data;
			end
		end
	end
endmodule
`default_nettype wire

// ==== verilog/vqb_top.sv ====
// Purpose: virtual channel arbiter, frame segmenter and broadcast layer
// Assumes: buffers, credit logic and framing run on clk; buffer head is show-ahead
// Notes: registers on a plain port, read data one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module vqb_top (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// register port
	input wire logic [vqb_pkg::AW-1:0] reg_addr,
	input wire logic [vqb_pkg::DW-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [vqb_pkg::DW-1:0] reg_rdata,
	// outbound channel buffers
	input wire logic [vqb_pkg::NVC-1:0] vcb_avail,
	input wire logic [vqb_pkg::WORDW-1:0] vcb_rdata,
	input wire logic vcb_last,
	output logic vcb_rd,
	output logic [vqb_pkg::VCW-1:0] vcb_sel,
	// flow credit receiver
	input wire logic [vqb_pkg::NVC-1:0] fct_credit,
	// data frames to framing layer
	input wire logic tx_ready,
	output logic tx_start,
	output logic [vqb_pkg::VCW-1:0] tx_vc,
	output logic tx_valid,
	output logic [vqb_pkg::WORDW-1:0] tx_word,
	output logic tx_end,
	// broadcast requests from user logic
	input wire logic ubt_req,
	input wire logic [vqb_pkg::BCW-1:0] ubt_chan,
	input wire logic [vqb_pkg::TYPW-1:0] ubt_type,
	input wire logic [vqb_pkg::PAYW-1:0] ubt_data,
	output logic ubt_drop,
	// broadcasts to framing layer
	output logic bft_valid,
	output logic [vqb_pkg::BCW-1:0] bft_chan,
	output logic [vqb_pkg::SEQW-1:0] bft_seq,
	output logic [vqb_pkg::TYPW-1:0] bft_type,
	output logic [vqb_pkg::PAYW-1:0] bft_data,
	// broadcasts from framing layer
	input wire logic bfr_valid,
	input wire logic [vqb_pkg::BCW-1:0] bfr_chan,
	input wire logic [vqb_pkg::SEQW-1:0] bfr_seq,
	input wire logic [vqb_pkg::TYPW-1:0] bfr_type,
	input wire logic [vqb_pkg::PAYW-1:0] bfr_data,
	// broadcasts to user logic
	output logic urx_valid,
	output logic [vqb_pkg::BCW-1:0] urx_chan,
	output logic [vqb_pkg::SEQW-1:0] urx_seq,
	output logic [vqb_pkg::TYPW-1:0] urx_type,
	output logic [vqb_pkg::PAYW-1:0] urx_data
);
	// configuration and state
	logic [vqb_pkg::DW-1:0] ctrl;
	logic [vqb_pkg::DW-1:0] type_mask;
	logic [vqb_pkg::DW-1:0] ltime;
	logic [vqb_pkg::DW-1:0] vc_cfg [vqb_pkg::NVC];
	logic [vqb_pkg::BWW-1:0] bw_cnt [vqb_pkg::NVC];
	logic [vqb_pkg::SLW-1:0] sync_slot;
	logic [vqb_pkg::SLW-1:0] slot;
	vqb_pkg::vqb_state_t state;
	logic [vqb_pkg::VCW-1:0] cur;
	logic [vqb_pkg::VCW-1:0] rr;
	logic [vqb_pkg::FCW-1:0] fcnt;
	logic [vqb_pkg::NVC-1:0] elig;
	logic [vqb_pkg::NVC*vqb_pkg::PRECW-1:0] prec;
	logic found;
	logic [vqb_pkg::VCW-1:0] win;
	logic frame_done;
	logic next_rd;
	logic [vqb_pkg::SEQW-1:0] tx_seq [vqb_pkg::NBC];
	logic [vqb_pkg::NBC-1:0] tx_used;
	logic [vqb_pkg::SEQW-1:0] next_seq;
	logic bt_ok;
	logic rx_acc;
	logic [vqb_pkg::BCW-1:0] rx_chan;
	logic [vqb_pkg::TYPW-1:0] rx_type;
	logic [vqb_pkg::PAYW-1:0] rx_data;
	logic sub_wr;

	// channel config decode, shared by write and read paths
	function automatic logic cfg_hit(input logic [vqb_pkg::AW-1:0] a);
		return a[7:4] == vqb_pkg::REG_VC_CFG[7:4] && {1'b0, a[3:2]} < 3'(vqb_pkg::NVC) && a[1:0] == 2'b00;
	endfunction

	// saturating share counter step
	function automatic logic [vqb_pkg::BWW-1:0] bw_step(input logic [vqb_pkg::BWW-1:0] c,
		input logic [7:0] rsv, input logic sent);
		logic [vqb_pkg::BWW+1:0] s;
		s = {2'b00, c} + {4'h0, rsv};
		if (sent) begin
			s = (s < vqb_pkg::BW_COST) ? '0 : s - vqb_pkg::BW_COST;
		end
		return (s > 12'h3ff) ? 10'h3ff : s[vqb_pkg::BWW-1:0];
	endfunction

	// control register
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl <= vqb_pkg::CTRL_RST;
		end else if (reg_wr && reg_addr == vqb_pkg::REG_CTRL) begin
			ctrl <= {30'h0, reg_wdata[1:0]};
		end
	end

	// subscribed type mask
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			type_mask <= vqb_pkg::TYPE_MASK_RST;
		end else if (reg_wr && reg_addr == vqb_pkg::REG_TYPE_MASK) begin
			type_mask <= reg_wdata;
		end
	end

	// per-channel service class settings
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < vqb_pkg::NVC; i++) begin
				vc_cfg[i] <= vqb_pkg::CFG_RST;
			end
		end else if (reg_wr && cfg_hit(reg_addr)) begin
			vc_cfg[reg_addr[3:2]] <= {8'h00, reg_wdata[23:8], 2'b00, reg_wdata[5:4], 1'b0, reg_wdata[2:0]};
		end
	end

	// local time: time broadcast beats software write beats counting
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ltime <= '0;
		end else if (rx_acc && rx_chan <= vqb_pkg::BC_TIME_HI && rx_type == vqb_pkg::TYPE_TIME) begin
			ltime <= rx_data[31:0];
		end else if (reg_wr && reg_addr == vqb_pkg::REG_LTIME) begin
			ltime <= reg_wdata;
		end else begin
			ltime <= ltime + 32'h1;
		end
	end

	// slot counter stepped by each accepted sync broadcast
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			sync_slot <= '0;
		end else if (rx_acc && rx_chan >= vqb_pkg::BC_SYNC_LO && rx_chan <= vqb_pkg::BC_SYNC_HI) begin
			sync_slot <= sync_slot + 3'h1;
		end
	end

	// current slot from the selected source
	assign slot = ctrl[vqb_pkg::CTRL_SLOT_SRC] ? sync_slot
		: ltime[vqb_pkg::LTIME_SLOT +: vqb_pkg::SLW];

	// eligibility and precedence of each channel
	for (genvar g = 0; g < vqb_pkg::NVC; g++) begin : g_prec
		vqb_pkg::vqb_class_t cls;
		logic in_slot;
		logic [vqb_pkg::PRW-1:0] lvl;
		logic [vqb_pkg::BWW-1:0] share;
		assign cls = vqb_pkg::vqb_class_t'(vc_cfg[g][vqb_pkg::CFG_CLASS +: 2]);
		assign in_slot = vc_cfg[g][vqb_pkg::CFG_SLOT + 32'(slot)];
		assign lvl = (cls == vqb_pkg::CL_BEST) ? '0 : vc_cfg[g][vqb_pkg::CFG_PRIO +: vqb_pkg::PRW];
		assign share = (cls == vqb_pkg::CL_BW) ? bw_cnt[g] : '0;
		assign elig[g] = vcb_avail[g] && fct_credit[g] && in_slot;
		// scheduled owner first, then level, then share
		assign prec[g*vqb_pkg::PRECW +: vqb_pkg::PRECW] =
			{cls == vqb_pkg::CL_SCHED, lvl, share};
	end

	vqb_arb u_arb (
		.elig(elig),
		.prec(prec),
		.rr(rr),
		.found(found),
		.win(win)
	);

	// share counters move once per word popped
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < vqb_pkg::NVC; i++) begin
				bw_cnt[i] <= vqb_pkg::BW_RST;
			end
		end else if (vcb_rd) begin
			for (int i = 0; i < vqb_pkg::NVC; i++) begin
				if (i[vqb_pkg::VCW-1:0] == cur) begin
					bw_cnt[i] <= bw_step(bw_cnt[i], vc_cfg[i][vqb_pkg::CFG_RSV +: 8], 1'b1);
				end else if (elig[i]) begin
					bw_cnt[i] <= bw_step(bw_cnt[i], vc_cfg[i][vqb_pkg::CFG_RSV +: 8], 1'b0);
				end
			end
		end
	end

	// frame ends on the buffer's last word or the 64th word
	assign frame_done = vcb_rd && (vcb_last || fcnt == vqb_pkg::FRAME_LAST);
	assign next_rd = state == vqb_pkg::ST_SEND && tx_ready && !frame_done;

	// frame sequencer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state <= vqb_pkg::ST_ARB;
			cur <= '0;
			rr <= '0;
		end else begin
			unique case (state)
				vqb_pkg::ST_ARB: begin
					if (ctrl[vqb_pkg::CTRL_ARB_EN] && found) begin
						state <= vqb_pkg::ST_SEND;
						cur <= win;
						rr <= win + 2'h1;
					end
				end
				vqb_pkg::ST_SEND: begin
					if (frame_done) begin
						state <= vqb_pkg::ST_GAP;
					end
				end
				vqb_pkg::ST_GAP: begin
					state <= vqb_pkg::ST_ARB;
				end
			endcase
		end
	end

	// buffer read strobes and word count
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			vcb_rd <= 1'b0;
			vcb_sel <= '0;
			fcnt <= '0;
		end else begin
			vcb_rd <= next_rd;
			vcb_sel <= (state == vqb_pkg::ST_ARB) ? win : cur;
			if (state == vqb_pkg::ST_ARB) begin
				fcnt <= '0;
			end else if (vcb_rd) begin
				fcnt <= fcnt + 6'h1;
			end
		end
	end

	// words and delimiters toward the framing layer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_start <= 1'b0;
			tx_vc <= '0;
			tx_valid <= 1'b0;
			tx_word <= '0;
			tx_end <= 1'b0;
		end else begin
			tx_start <= state == vqb_pkg::ST_ARB && ctrl[vqb_pkg::CTRL_ARB_EN] && found;
			if (state == vqb_pkg::ST_ARB) begin
				tx_vc <= win;
			end
			tx_valid <= vcb_rd;
			tx_end <= frame_done;
			if (vcb_rd) begin
				tx_word <= vcb_rdata;
			end
		end
	end

	// transmit sequence numbers, unused channels start at one
	assign bt_ok = ubt_req && !vqb_pkg::vqb_is_rsv(ubt_chan);
	assign next_seq = (tx_used[ubt_chan] ? tx_seq[ubt_chan] : 8'h00) + 8'h01;

	// counter store, one per broadcast channel
	always_ff @(posedge clk) begin
		if (bt_ok) begin
			tx_seq[ubt_chan] <= next_seq;
		end
	end

	// which counters hold a value
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			tx_used <= '0;
		end else if (bt_ok) begin
			tx_used[ubt_chan] <= 1'b1;
		end
	end

	// broadcast hand-off to the framing layer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bft_valid <= 1'b0;
			bft_chan <= '0;
			bft_seq <= '0;
			bft_type <= '0;
			bft_data <= '0;
			ubt_drop <= 1'b0;
		end else begin
			bft_valid <= bt_ok;
			ubt_drop <= ubt_req && !bt_ok;
			if (bt_ok) begin
				bft_chan <= ubt_chan;
				bft_seq <= next_seq;
				bft_type <= ubt_type;
				bft_data <= ubt_data;
			end
		end
	end

	// subscription writes: bit 8 on or off, low byte channel
	assign sub_wr = reg_wr && reg_addr == vqb_pkg::REG_SUB;

	vqb_brx u_brx (
		.clk(clk),
		.arst_n(arst_n),
		.in_valid(bfr_valid),
		.in_chan(bfr_chan),
		.in_seq(bfr_seq),
		.in_type(bfr_type),
		.in_data(bfr_data),
		.sub_wr(sub_wr),
		.sub_chan(reg_wdata[7:0]),
		.sub_on(reg_wdata[vqb_pkg::SUB_ON]),
		.type_mask(type_mask),
		.acc(rx_acc),
		.dlv(urx_valid),
		.d_chan(rx_chan),
		.d_seq(urx_seq),
		.d_type(rx_type),
		.d_data(rx_data)
	);
	assign urx_chan = rx_chan;
	assign urx_type = rx_type;
	assign urx_data = rx_data;

	// register read, unmapped reads as zero
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= '0;
		end else if (!reg_rd) begin
			reg_rdata <= '0;
		end else if (cfg_hit(reg_addr)) begin
			reg_rdata <= vc_cfg[reg_addr[3:2]];
		end else begin
			unique case (reg_addr)
				vqb_pkg::REG_CTRL: reg_rdata <= ctrl;
				vqb_pkg::REG_STATUS: reg_rdata <= {24'h0, state != vqb_pkg::ST_ARB, 1'b0, cur, 1'b0, slot};
				vqb_pkg::REG_TYPE_MASK: reg_rdata <= type_mask;
				vqb_pkg::REG_LTIME: reg_rdata <= ltime;
				default: reg_rdata <= '0;
			endcase
		end
	end
endmodule
`default_nettype wire

// ==== test/vqb_top_monitor.sv ====
// Purpose: port checks for vqb_top
// Assumes: one clock, async active-low reset
// Notes: bound to every vqb_top instance
`timescale 1ns/1ps
`default_nettype none
module vqb_top_monitor (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// register and frame side
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic [3:0] vcb_avail,
	input wire logic [3:0] fct_credit,
	input wire logic vcb_rd,
	input wire logic tx_start,
	input wire logic [1:0] tx_vc,
	input wire logic tx_valid,
	input wire logic tx_end,
	// broadcast side
	input wire logic ubt_req,
	input wire logic [7:0] ubt_chan,
	input wire logic ubt_drop,
	input wire logic bft_valid,
	input wire logic [7:0] bft_chan,
	input wire logic bfr_valid,
	input wire logic [7:0] bfr_chan,
	input wire logic [7:0] bfr_seq,
	input wire logic urx_valid,
	input wire logic [7:0] urx_chan,
	input wire logic [7:0] urx_seq
);
	logic [3:0] elig_q;
	logic [6:0] wcnt;
	default clocking @(posedge clk);
	endclocking
	default disable iff (!arst_n);
	// eligibility one cycle back, words sent in frame
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			elig_q <= 4'h0;
			wcnt <= 7'h00;
		end else begin
			elig_q <= vcb_avail & fct_credit;
			if (tx_start) wcnt <= 7'h00;
			else if (tx_valid) wcnt <= wcnt + 7'h01;
		end
	end
	rd_answer_a: assert property (reg_rdata != 32'h0 |-> $past(reg_rd))
		else $error("read data without read strobe");
	grant_elig_a: assert property (tx_start |-> elig_q[tx_vc])
		else $error("grant to channel without data or credit");
	word_pop_a: assert property (tx_valid |-> $past(vcb_rd))
		else $error("word sent without buffer pop");
	frame_len_a: assert property (tx_valid |-> wcnt < 7'h40)
		else $error("frame longer than 64 words");
	frame_gap_a: assert property (tx_end |=> !tx_start)
		else $error("next grant too soon after frame end");
	bc_send_a: assert property (ubt_req && ubt_chan < 8'hfe |=> bft_valid && bft_chan == $past(ubt_chan))
		else $error("broadcast request not passed on");
	bc_drop_a: assert property (ubt_req && ubt_chan > 8'hfd |=> ubt_drop && !bft_valid)
		else $error("reserved channel broadcast not refused");
	bc_cause_a: assert property (bft_valid || ubt_drop |-> $past(ubt_req))
		else $error("broadcast output without request");
	rx_deliver_a: assert property (urx_valid |-> $past(bfr_valid) && urx_chan == $past(bfr_chan)
		&& urx_seq == $past(bfr_seq))
		else $error("delivered message differs from received");
	rx_reserved_a: assert property (bfr_valid && bfr_chan > 8'hfd |=> !urx_valid)
		else $error("reserved channel message delivered");
endmodule
bind vqb_top vqb_top_monitor mon_u (.clk(clk), .arst_n(arst_n), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.vcb_avail(vcb_avail), .fct_credit(fct_credit), .vcb_rd(vcb_rd), .tx_start(tx_start), .tx_vc(tx_vc),
	.tx_valid(tx_valid), .tx_end(tx_end), .ubt_req(ubt_req), .ubt_chan(ubt_chan), .ubt_drop(ubt_drop),
	.bft_valid(bft_valid), .bft_chan(bft_chan), .bfr_valid(bfr_valid), .bfr_chan(bfr_chan),
	.bfr_seq(bfr_seq), .urx_valid(urx_valid), .urx_chan(urx_chan), .urx_seq(urx_seq));
`default_nettype wire

// ==== test/vqb_far_model.sv ====
// Purpose: outbound buffers and credit receiver beside vqb_top
// Assumes: show-ahead heads, one credit per channel
// Notes: head word carries channel and words left
`timescale 1ns/1ps
`default_nettype none
module vqb_far_model (
	// clock and reset
	input wire logic clk,
	input wire logic arst_n,
	// bench control
	input wire logic load_en,
	input wire logic [1:0] load_vc,
	input wire logic [7:0] load_n,
	input wire logic [3:0] cred_set,
	// design side
	input wire logic vcb_rd,
	input wire logic [1:0] vcb_sel,
	input wire logic tx_start,
	input wire logic [1:0] tx_vc,
	output logic [3:0] vcb_avail,
	output logic [35:0] vcb_rdata,
	output logic vcb_last,
	output logic [3:0] fct_credit
);
	logic [7:0] cnt [4];
	// words held per buffer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 4; i++) cnt[i] <= 8'h00;
		end else begin
			if (vcb_rd) cnt[vcb_sel] <= cnt[vcb_sel] - 8'h01;
			if (load_en) cnt[load_vc] <= load_n;
		end
	end
	// credit granted by bench, spent at frame start
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) fct_credit <= 4'h0;
		else fct_credit <= (fct_credit | cred_set) & ~(tx_start ? 4'h1 << tx_vc : 4'h0);
	end
	// buffer state seen by the arbiter
	always_comb begin
		for (int i = 0; i < 4; i++) vcb_avail[i] = cnt[i] != 8'h00;
	end
	assign vcb_rdata = {vcb_sel, 26'h0, cnt[vcb_sel]};
	assign vcb_last = cnt[vcb_sel] == 8'h01;
endmodule
`default_nettype wire

// ==== test/vqb_top_test.sv ====
// Purpose: self-checking bench for vqb_top
// Assumes: far model supplies buffers and credit
// Notes: framing always ready
`timescale 1ns/1ps
`default_nettype none
module vqb_top_test;
	logic clk = 1'b0, arst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tx_ready = 1'b1;
	logic ubt_req = 1'b0, bfr_valid = 1'b0, load_en = 1'b0;
	logic [7:0] reg_addr = 8'h00, ubt_chan = 8'h00, bfr_chan = 8'h00, bfr_seq = 8'h00, load_n = 8'h00;
	logic [7:0] ubt_type = 8'h00, bfr_type = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [63:0] ubt_data = 64'h0, bfr_data = 64'h0, bft_data, urx_data;
	logic [3:0] vcb_avail, fct_credit, cred_set = 4'h0;
	logic [35:0] vcb_rdata, tx_word;
	logic [1:0] vcb_sel, tx_vc, load_vc = 2'h0;
	logic [7:0] bft_chan, bft_seq, bft_type, urx_chan, urx_seq, urx_type;
	logic vcb_last, vcb_rd, tx_start, tx_valid, tx_end, ubt_drop, bft_valid, urx_valid;
	logic [1:0] grants[$];
	logic [1:0] eg[5] = '{2'h1, 2'h0, 2'h2, 2'h1, 2'h3};
	int el[5] = '{64, 3, 2, 6, 5};
	int lens[$];
	int miscompares = 0, tests_run = 0, cycles = 0, nw = 0;
	vqb_top dut_u (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .vcb_avail(vcb_avail), .vcb_rdata(vcb_rdata),
		.vcb_last(vcb_last), .vcb_rd(vcb_rd), .vcb_sel(vcb_sel), .fct_credit(fct_credit),
		.tx_ready(tx_ready), .tx_start(tx_start), .tx_vc(tx_vc), .tx_valid(tx_valid), .tx_word(tx_word),
		.tx_end(tx_end), .ubt_req(ubt_req), .ubt_chan(ubt_chan), .ubt_type(ubt_type), .ubt_data(ubt_data),
		.ubt_drop(ubt_drop), .bft_valid(bft_valid), .bft_chan(bft_chan), .bft_seq(bft_seq),
		.bft_type(bft_type), .bft_data(bft_data), .bfr_valid(bfr_valid), .bfr_chan(bfr_chan),
		.bfr_seq(bfr_seq), .bfr_type(bfr_type), .bfr_data(bfr_data), .urx_valid(urx_valid),
		.urx_chan(urx_chan), .urx_seq(urx_seq), .urx_type(urx_type), .urx_data(urx_data));
	vqb_far_model far_u (.clk(clk), .arst_n(arst_n), .load_en(load_en), .load_vc(load_vc),
		.load_n(load_n), .cred_set(cred_set), .vcb_rd(vcb_rd), .vcb_sel(vcb_sel), .tx_start(tx_start),
		.tx_vc(tx_vc), .vcb_avail(vcb_avail), .vcb_rdata(vcb_rdata), .vcb_last(vcb_last),
		.fct_credit(fct_credit));
	// 20 MHz clock
	always #25 clk = ~clk;
	task automatic end_of_test();
		if (miscompares == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic check(input logic [95:0] seen, input logic [95:0] exp);
		tests_run++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// grant order, frame lengths, hang limit
	always @(posedge clk) begin
		cycles++;
		if (tx_start) grants.push_back(tx_vc);
		if (tx_start) nw = 0;
		if (tx_valid) nw++;
		if (tx_valid) check(tx_word[35:34], tx_vc);
		if (tx_end) lens.push_back(nw);
		if (cycles == 20000) begin
			miscompares++;
			end_of_test();
		end
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask
	task automatic far(input logic [1:0] v, input logic [7:0] n, input logic [3:0] c);
		@(posedge clk);
		load_en <= n != 8'h00;
		load_vc <= v;
		load_n <= n;
		cred_set <= c;
		@(posedge clk);
		load_en <= 1'b0;
		cred_set <= 4'h0;
	endtask
	task automatic wait_frames(input int n);
		for (int t = 0; t < 3000 && lens.size() < n; t++) @(posedge clk);
		check(lens.size(), n);
	endtask
	task automatic bt(input logic [7:0] ch, input logic [7:0] sq, input logic drop);
		@(posedge clk);
		ubt_req <= 1'b1;
		ubt_chan <= ch;
		ubt_data <= {ch, 48'h0, sq};
		ubt_type <= ~sq;
		@(posedge clk);
		ubt_req <= 1'b0;
		#1 check({bft_valid, ubt_drop}, {~drop, drop});
		if (!drop) check({bft_chan, bft_seq, bft_type, bft_data}, {ch, sq, ~sq, ch, 48'h0, sq});
	endtask
	task automatic br(input logic [7:0] ch, input logic [7:0] sq, input logic exp);
		@(posedge clk);
		bfr_valid <= 1'b1;
		bfr_chan <= ch;
		bfr_seq <= sq;
		bfr_data <= {sq, 48'h0, ch};
		// time channels carry time messages
		bfr_type <= (ch < 8'h04) ? vqb_pkg::TYPE_TIME : 8'h02;
		@(posedge clk);
		bfr_valid <= 1'b0;
		#1 check(urx_valid, exp);
		if (exp) check({urx_chan, urx_seq, urx_type, urx_data}, {ch, sq, 8'h02, sq, 48'h0, ch});
	endtask
	initial begin
		repeat (20) @(posedge clk);
		arst_n <= 1'b1;
		rd_chk(vqb_pkg::REG_CTRL, vqb_pkg::CTRL_RST);
		rd_chk(vqb_pkg::REG_TYPE_MASK, vqb_pkg::TYPE_MASK_RST);
		rd_chk(8'h40, 32'h0);
		wr(vqb_pkg::REG_VC_CFG + 8'h0c, 32'hffff_ffff);
		rd_chk(vqb_pkg::REG_VC_CFG + 8'h0c, 32'h00ff_ff37);
		rd_chk(vqb_pkg::REG_VC_CFG, vqb_pkg::CFG_RST);
		// two priority levels, best effort at top level, one unscheduled
		wr(vqb_pkg::REG_VC_CFG, 32'h00ff_0012);
		wr(vqb_pkg::REG_VC_CFG + 8'h04, 32'h00ff_0015);
		wr(vqb_pkg::REG_VC_CFG + 8'h08, 32'h00ff_0007);
		wr(vqb_pkg::REG_VC_CFG + 8'h0c, 32'h0000_0017);
		far(2'h0, 8'd3, 4'h0);
		far(2'h1, 8'd70, 4'h0);
		far(2'h2, 8'd2, 4'h0);
		far(2'h3, 8'd5, 4'hf);
		wait_frames(3);
		far(2'h0, 8'h00, 4'h2);
		wait_frames(4);
		wr(vqb_pkg::REG_VC_CFG + 8'h0c, 32'h00ff_0017);
		wait_frames(5);
		for (int i = 0; i < 5; i++) check(grants[i], eg[i]);
		for (int i = 0; i < 5; i++) check(lens[i], el[i]);
		// transmit sequence numbers
		bt(8'h05, 8'h01, 1'b0);
		bt(8'h05, 8'h02, 1'b0);
		bt(8'hfe, 8'h00, 1'b1);
		bt(8'hff, 8'h00, 1'b1);
		bt(8'h05, 8'h03, 1'b0);
		for (int i = 1; i <= 256; i++) bt(8'h20, i[7:0], 1'b0);
		// receive validation and subscriptions
		wr(vqb_pkg::REG_SUB, 32'h0000_0109);
		wr(vqb_pkg::REG_SUB, 32'h0000_010c);
		br(8'h09, 8'd40, 1'b1);
		br(8'h09, 8'd41, 1'b1);
		br(8'h09, 8'd43, 1'b0);
		br(8'h0a, 8'd1, 1'b0);
		wr(vqb_pkg::REG_TYPE_MASK, 32'hffff_fffb);
		br(8'h09, 8'd42, 1'b0);
		wr(vqb_pkg::REG_TYPE_MASK, 32'hffff_ffff);
		br(8'h09, 8'd43, 1'b1);
		br(8'h0c, 8'hff, 1'b1);
		br(8'h0c, 8'h00, 1'b1);
		br(8'hfe, 8'h01, 1'b0);
		wr(vqb_pkg::REG_SUB, 32'h0000_0009);
		br(8'h09, 8'd44, 1'b0);
		// local time, time and sync broadcasts, slot source
		wr(vqb_pkg::REG_LTIME, 32'h0000_1c00);
		rd_chk(vqb_pkg::REG_LTIME, 32'h0000_1c01);
		br(8'h00, 8'h05, 1'b0);
		rd_chk(vqb_pkg::REG_LTIME, 32'h0000_0000);
		br(8'h04, 8'h07, 1'b0);
		wr(vqb_pkg::REG_CTRL, 32'h0000_0003);
		rd_chk(vqb_pkg::REG_STATUS, 32'h0000_0031);
		end_of_test();
	end
endmodule
`default_nettype wire
